// ---- crmc_core_regulator.sv ----
// Core regulator mode control: operating mode, voltage mode, clock stop and discharge.
// Assumes oscillator activity flags and one-cycle oscillator ticks synchronous to core_clk.

`timescale 1ns/1ps

module crmc_core_regulator #(
  parameter logic [11:0] SLOW_WAIT_0 = crmc_pkg::SLOW_WAIT_0,
  parameter logic [11:0] SLOW_WAIT_1 = crmc_pkg::SLOW_WAIT_1,
  parameter logic [11:0] SLOW_WAIT_2 = crmc_pkg::SLOW_WAIT_2,
  parameter logic [11:0] SLOW_WAIT_3 = crmc_pkg::SLOW_WAIT_3
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // Clock source state.
  input wire logic internal_oscillator_active,
  input wire logic slow_crystal_osc_active,
  input wire logic fast_crystal_osc_active,
  input wire logic external_clock_input_active,
  input wire logic sysclk_is_slow_crystal,
  input wire logic internal_oscillator_tick,
  input wire logic slow_crystal_osc_tick,
  input wire logic [1:0] slow_osc_wait_count,
  // Regulator and clock controls.
  output logic reg_economy,
  output logic reg_low_voltage,
  output logic reg_discharge,
  output logic sysclk_halt,
  output logic rtc_clk_halt
);
  typedef enum logic [1:0] {
    CRMC_IDLE = 2'b01,
    CRMC_HALT = 2'b10
  } crmc_state_t;

  crmc_state_t state_reg;
  crmc_state_t state_next;
  logic [15:0] protect_key_reg;
  logic voltage_mode_select_reg;
  logic supply_discharge_ctl_reg;
  logic [1:0] regulator_op_mode_reg;
  logic unlocked;
  logic ctl_wr;
  logic vsel_change;
  logic light_load;
  logic halt_slow_reg;
  logic halt_busy;
  logic rtc_busy;
  logic halt_tick;
  logic slow_tick;
  logic [11:0] slow_len;
  logic [11:0] halt_len;

  function automatic logic [11:0] slow_wait_len(input logic [1:0] sel);
    case (sel)
      2'h0: slow_wait_len = SLOW_WAIT_0;
      2'h1: slow_wait_len = SLOW_WAIT_1;
      2'h2: slow_wait_len = SLOW_WAIT_2;
      default: slow_wait_len = SLOW_WAIT_3;
    endcase
  endfunction : slow_wait_len

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes.

  assign unlocked = (protect_key_reg == crmc_pkg::PROTECT_UNLOCK);
  assign ctl_wr = wr_en && (addr == crmc_pkg::OFF_REG_CTL) && unlocked;
  assign vsel_change = ctl_wr && (wdata[crmc_pkg::VSEL_BIT] != voltage_mode_select_reg);

  // The key itself is never protected, so software can always unlock or relock.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      protect_key_reg <= crmc_pkg::PROTECT_RESET;
    end else if (wr_en && addr == crmc_pkg::OFF_PROTECT) begin
      protect_key_reg <= wdata[15:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      voltage_mode_select_reg <= crmc_pkg::VSEL_RESET;
      supply_discharge_ctl_reg <= crmc_pkg::DISCH_RESET;
      regulator_op_mode_reg <= crmc_pkg::OPMODE_RESET;
    end else if (ctl_wr) begin
      voltage_mode_select_reg <= wdata[crmc_pkg::VSEL_BIT];
      supply_discharge_ctl_reg <= wdata[crmc_pkg::DISCH_BIT];
      regulator_op_mode_reg <= wdata[crmc_pkg::OPMODE_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads, one cycle after the strobe.

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata <= 32'h0000_0000;
      case (addr)
        crmc_pkg::OFF_PROTECT: begin
          rdata[15:0] <= protect_key_reg;
        end
        crmc_pkg::OFF_REG_CTL: begin
          rdata[crmc_pkg::VSEL_BIT] <= voltage_mode_select_reg;
          rdata[crmc_pkg::DISCH_BIT] <= supply_discharge_ctl_reg;
          rdata[crmc_pkg::OPMODE_LSB +: 2] <= regulator_op_mode_reg;
        end
        crmc_pkg::OFF_STATUS: begin
          rdata[crmc_pkg::ST_HALT_BIT] <= sysclk_halt;
          rdata[crmc_pkg::ST_ECO_BIT] <= reg_economy;
          rdata[crmc_pkg::ST_LIGHT_BIT] <= light_load;
          rdata[crmc_pkg::ST_RTC_HALT_BIT] <= rtc_clk_halt;
        end
        default: begin
          rdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Regulator operating mode.

  // Any running source other than the slow crystal means a real load.
  assign light_load = !internal_oscillator_active && !fast_crystal_osc_active
    && !external_clock_input_active;

  // Undefined mode codes fall back to normal, the safe choice for the supply.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_economy <= 1'b0;
    end else if (regulator_op_mode_reg == crmc_pkg::OPMODE_AUTO) begin
      reg_economy <= light_load;
    end else begin
      reg_economy <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_low_voltage <= 1'b0;
      reg_discharge <= 1'b0;
    end else begin
      reg_low_voltage <= !voltage_mode_select_reg;
      reg_discharge <= supply_discharge_ctl_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // System clock stop after a voltage mode change.

  // A stopped crystal raises no tick, so a stray pulse on its tick input is ignored.
  assign slow_tick = slow_crystal_osc_tick && slow_crystal_osc_active;
  assign slow_len = slow_wait_len(slow_osc_wait_count);
  assign halt_len = sysclk_is_slow_crystal ? slow_len
    : crmc_pkg::INTERNAL_OSC_STOP_CYCLES;
  assign halt_tick = halt_slow_reg ? slow_tick : internal_oscillator_tick;

  // The tick source is frozen when a stop begins, so a clock switch mid-stop cannot stretch it.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      halt_slow_reg <= 1'b0;
    end else if (vsel_change && state_reg == CRMC_IDLE) begin
      halt_slow_reg <= sysclk_is_slow_crystal;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CRMC_IDLE: begin
        if (vsel_change) begin
          state_next = CRMC_HALT;
        end
      end
      CRMC_HALT: begin
        if (!halt_busy) begin
          state_next = CRMC_IDLE;
        end
      end
      default: begin
        state_next = CRMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= CRMC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sysclk_halt = (state_reg == CRMC_HALT);

  crmc_stop_timer #(
    .W(crmc_pkg::TIMER_W)
  ) u_sys_timer (
    .core_clk(core_clk),
    .srst(srst),
    .start(vsel_change && state_reg == CRMC_IDLE),
    .tick(halt_tick),
    .length(halt_len),
    .busy(halt_busy)
  );

  // The real-time clock source stops for the slow crystal wait count at each change made while it is not already stopped.
  crmc_stop_timer #(
    .W(crmc_pkg::TIMER_W)
  ) u_rtc_timer (
    .core_clk(core_clk),
    .srst(srst),
    .start(vsel_change && !rtc_busy),
    .tick(slow_tick),
    .length(slow_len),
    .busy(rtc_busy)
  );

  assign rtc_clk_halt = rtc_busy;
endmodule : crmc_core_regulator

// ---- crmc_stop_timer.sv ----
// Shared constants of the core regulator mode control block, and its stop-period timer.
// The timer counts enable ticks of a slower oscillator that arrive on the one core clock.

`timescale 1ns/1ps

package crmc_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_PROTECT = 8'h00;
  localparam logic [7:0] OFF_REG_CTL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  // Protection key.
  localparam logic [15:0] PROTECT_UNLOCK = 16'h0096;
  localparam logic [15:0] PROTECT_RESET = 16'h0000;
  // Field positions in the regulator control register.
  localparam int VSEL_BIT = 0;
  localparam int DISCH_BIT = 1;
  localparam int OPMODE_LSB = 4;
  // Field positions in the status register.
  localparam int ST_HALT_BIT = 0;
  localparam int ST_ECO_BIT = 1;
  localparam int ST_LIGHT_BIT = 2;
  localparam int ST_RTC_HALT_BIT = 3;
  // Reset values: high voltage mode, no discharge, automatic operation.
  localparam logic VSEL_RESET = 1'b1;
  localparam logic DISCH_RESET = 1'b0;
  // Operating mode codes.
  localparam logic [1:0] OPMODE_AUTO = 2'h0;
  localparam logic [1:0] OPMODE_NORMAL = 2'h2;
  localparam logic [1:0] OPMODE_RESET = OPMODE_AUTO;
  // Stop period, in oscillator cycles.
  localparam int TIMER_W = 12;
  localparam logic [TIMER_W-1:0] INTERNAL_OSC_STOP_CYCLES = 12'h800;
  localparam logic [TIMER_W-1:0] SLOW_WAIT_0 = 12'h010;
  localparam logic [TIMER_W-1:0] SLOW_WAIT_1 = 12'h020;
  localparam logic [TIMER_W-1:0] SLOW_WAIT_2 = 12'h040;
  localparam logic [TIMER_W-1:0] SLOW_WAIT_3 = 12'h080;
endpackage : crmc_pkg

////////////////////////////////////////////////////////////////////////////////

module crmc_stop_timer #(
  parameter int W = 12
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Control.
  input wire logic start,
  input wire logic tick,
  input wire logic [W-1:0] length,
  // Status.
  output logic busy
);
  logic [W-1:0] count_reg;

  // A zero length is taken as one tick so that a stop never collapses to nothing.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_reg <= '0;
      busy <= 1'b0;
    end else if (start) begin
      count_reg <= (length == '0) ? W'(1) : length;
      busy <= 1'b1;
    end else if (busy && tick) begin
      count_reg <= count_reg - W'(1);
      if (count_reg == W'(1)) begin
        busy <= 1'b0;
      end
    end
  end
endmodule : crmc_stop_timer

// ---- crmc_chk.sv ----
// Concurrent checks on the ports of the core regulator mode control block.
// Assumes strobes and oscillator flags change only just after a core_clk edge.
`timescale 1ns/1ps
module crmc_chk (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  // Sources and controls.
  input wire logic internal_oscillator_active,
  input wire logic fast_crystal_osc_active,
  input wire logic external_clock_input_active,
  input wire logic reg_economy,
  input wire logic reg_low_voltage,
  input wire logic reg_discharge,
  input wire logic sysclk_halt,
  input wire logic rtc_clk_halt
);
  logic [15:0] key_s;
  logic [3:0] ctl_s;
  logic ok;
  // Shadows move only on accepted writes, so a locked write must leave the outputs alone.
  assign ok = wr_en && addr == 8'h04 && key_s == 16'h0096;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      key_s <= 16'h0000;
      ctl_s <= 4'h1;
    end else begin
      if (wr_en && addr == 8'h00) key_s <= wdata[15:0];
      if (ok) ctl_s <= {wdata[5:4], wdata[1:0]};
    end
  end
////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  rd_idle_a: assert property (!rd_en |=> rdata == 32'h0)
    else $error("rdata not idle");
  key_rd_a: assert property (rd_en && addr == 8'h00 |=> rdata[15:0] == key_s)
    else $error("bad key readback");
  ctl_rd_a: assert property (rd_en && addr == 8'h04 |=> {rdata[5:4], rdata[1:0]} == ctl_s)
    else $error("bad control readback");
  vsel_out_a: assert property (!$past(srst) |-> reg_low_voltage == !$past(ctl_s[0]))
    else $error("voltage mode wrong");
  disch_out_a: assert property (!$past(srst) |-> reg_discharge == $past(ctl_s[1]))
    else $error("discharge wrong");
  eco_out_a: assert property (!$past(srst) |-> reg_economy == $past(ctl_s[3:2] == 2'h0
    && !internal_oscillator_active && !fast_crystal_osc_active
    && !external_clock_input_active))
    else $error("economy wrong");
  halt_on_a: assert property (ok && wdata[0] != ctl_s[0] && !sysclk_halt
    |-> ##[1:2] sysclk_halt)
    else $error("no clock stop");
  rtc_on_a: assert property ($rose(rtc_clk_halt) |-> $rose(sysclk_halt))
    else $error("rtc stop alone");
  rtc_with_halt_a: assert property ($rose(sysclk_halt) |-> rtc_clk_halt)
    else $error("clock stop without rtc stop");
endmodule : crmc_chk
////////////////////////////////////////
bind crmc_core_regulator crmc_chk u_chk (.*);

// ---- tb.sv ----
// Self-checking bench for the core regulator mode control block.
// Assumes design and checker are compiled first; the bench plays software and oscillators.
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] WL [4] = '{12'h002, 12'h003, 12'h004, 12'h005};
  logic core_clk, srst, wr_en, rd_en, rd_q, internal_oscillator_tick, slow_crystal_osc_tick;
  logic internal_oscillator_active, slow_crystal_osc_active, fast_crystal_osc_active;
  logic external_clock_input_active, sysclk_is_slow_crystal;
  logic reg_economy, reg_low_voltage, reg_discharge, sysclk_halt, rtc_clk_halt;
  logic [1:0] slow_osc_wait_count;
  logic [2:0] v;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, k;
  logic [31:0] exp_q[$];
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  crmc_core_regulator #(.SLOW_WAIT_0(WL[0]), .SLOW_WAIT_1(WL[1]), .SLOW_WAIT_2(WL[2]),
    .SLOW_WAIT_3(WL[3])) u_dut (.*);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: %h not %h", $time, s, e);
    end
  endtask : chk
  // A read hands over its expected data, which the watcher compares a cycle later.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr_en <= w;
    rd_en <= !w;
    addr <= a;
    wdata <= d;
    if (!w) exp_q.push_back(d);
  endtask : bus
  task automatic idle();
    @(posedge core_clk);
    {wr_en, rd_en} <= 2'h0;
  endtask : idle
  task automatic halt(input int want);
    int t;
    t = 0;
    while (sysclk_halt !== 1'b1 && t < 4) begin
      @(posedge core_clk);
      t++;
    end
    t = 0;
    while (sysclk_halt === 1'b1 && t < 10000) begin
      @(posedge core_clk);
      t++;
    end
    chk(32'(t > want - 12 && t < want + 12), 32'h1);
  endtask : halt
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
////////////////////////////////////////
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    internal_oscillator_tick <= cyc % 4 == 0;
    slow_crystal_osc_tick <= cyc % 8 == 3;
    rd_q <= rd_en;
    if (rd_q) chk(rdata, exp_q.pop_front());
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    srst = 1'b1;
    {wr_en, rd_en, rd_q} = 3'h0;
    {internal_oscillator_tick, slow_crystal_osc_tick, sysclk_is_slow_crystal} = 3'h0;
    {internal_oscillator_active, slow_crystal_osc_active} = 2'h3;
    {fast_crystal_osc_active, external_clock_input_active} = 2'h3;
    addr = 8'h0;
    wdata = 32'h0;
    slow_osc_wait_count = 2'h0;
    void'($urandom(32'h9cf2fd38));
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b0, 8'h04, 32'h1);
    bus(1'b0, 8'h00, 32'h0);
    bus(1'b0, 8'h08, 32'h0);
    idle();
    $display("reset test done");
    // Fast crystal and external clock are stopped before the low mode change; the economy loop later drives them at random.
    {fast_crystal_osc_active, external_clock_input_active} <= 2'h0;
    bus(1'b1, 8'h00, 32'h96);
    bus(1'b1, 8'h04, 32'h22);
    idle();
    repeat (2) @(posedge core_clk);
    chk(32'(reg_low_voltage), 32'h1);
    chk(32'(reg_discharge), 32'h1);
    bus(1'b0, 8'h08, 32'h9);
    idle();
    halt(4 * int'(crmc_pkg::INTERNAL_OSC_STOP_CYCLES) - 4);
    $display("low mode test done");
    {internal_oscillator_active, sysclk_is_slow_crystal} <= 2'b01;
    for (int m = 3; m >= 0; m--) begin
      bus(1'b1, 8'h04, 32'(m) << 4);
      idle();
      bus(1'b0, 8'h08, {29'h0, 1'b1, m == 0, 1'b0});
      idle();
    end
    repeat (6) begin
      v = 3'($urandom);
      idle();
      {internal_oscillator_active, fast_crystal_osc_active, external_clock_input_active} <= v;
      bus(1'b0, 8'h08, {29'h0, v == 3'h0, v == 3'h0, 1'b0});
    end
    idle();
    $display("economy test done");
    for (int w = 0; w < 4; w++) begin
      slow_osc_wait_count <= 2'(w);
      bus(1'b1, 8'h04, {26'h0, 2'h2, 2'h0, w[0], !w[0]});
      idle();
      halt(8 * WL[w] - 2);
      chk(32'(reg_low_voltage), 32'(w[0]));
    end
    k = {16'h0, 16'($urandom)};
    if (k == 32'h96) k = 32'h0;
    bus(1'b1, 8'h00, k);
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b1, 8'h0c, 32'hff);
    bus(1'b0, 8'h00, k);
    bus(1'b0, 8'h04, 32'h22);
    bus(1'b0, 8'h0c, 32'h0);
    idle();
    repeat (3) @(posedge core_clk);
    chk(32'(sysclk_halt), 32'h0);
    $display("slow source and lock test done");
    complete_run();
  end
endmodule : tb
